// ### hw/usb_fdc_regs.vh
// register offsets, fields, reset values and timing for device control
`ifndef USB_FDC_REGS_VH
`define USB_FDC_REGS_VH
`define ADDR_OFS 12'h000
`define POWER_OFS 12'h004
`define INTEN_OFS 12'h008
`define INTFLG_OFS 12'h00C
`define EPSEL_OFS 12'h010
`define EPCSR_OFS 12'h014
`define PWR_ISO 7
`define PWR_INH 4
`define PWR_RST 3
`define PWR_RES 2
`define PWR_SUS 1
`define PWR_SUSDET 0
`define ADDR_RST 8'h00
`define INTEN_RST 8'h00
`define INTEN_BUSRST 8'hFE
`define INT_SUS 0
`define INT_RES 1
`define INT_RST 2
`define RST_PULSE_CYC 4'h4
`endif

// ### hw/usb_fdc_sreset.v
// stretched software reset generator for the usb function logic
`timescale 1ns/1ps
`default_nettype none
`include "usb_fdc_regs.vh"
module usb_fdc_sreset
(
   input wire I_MCLK,
   input wire I_RST,
   input wire i_req,
   output reg o_rst
);
reg [3:0] cnt_q;
// reset held for a few cycles so the apb answer completes cleanly first
always @(posedge I_MCLK or posedge I_RST)
begin
   if (I_RST)
   begin
      cnt_q <= 4'h0;
      o_rst <= 1'b0;
   end
   else
   begin
      if (i_req)
         cnt_q <= `RST_PULSE_CYC;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
      o_rst <= (cnt_q != 4'h0);
   end
end
endmodule
`default_nettype wire

// ### hw/usb_fdc.v
// usb function device-level control: address, bus reset, suspend, enable
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usb_fdc_regs.vh"
module usb_fdc
(
   input wire I_MCLK,
   input wire I_RST,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   input wire i_bus_reset,
   input wire i_bus_suspend,
   input wire i_bus_resume,
   input wire i_xfer_done,
   input wire i_sof,
   input wire i_iso_loaded,
   input wire i_iso_in_token,
   output reg [6:0] o_active_addr,
   output reg o_fifo_flush,
   output reg o_usb_enable,
   output reg o_suspended,
   output reg o_osc_wake,
   output reg o_resume_drive,
   output reg o_iso_send,
   output reg o_iso_zlp,
   output reg [7:0] o_int_flags
);
////////////////////////////////////////////////////////////////////////
wire usb_rst;
reg sw_rst_req;
wire rst_all = I_RST | usb_rst;
reg [2:0] brst_s, susp_s, res_s;
wire brst = brst_s[2];
wire brst_rise = brst_s[1] & ~brst_s[2];
wire susp_rise = susp_s[1] & ~susp_s[2];
wire res_rise = res_s[1] & ~res_s[2];
reg [6:0] addr_q;
reg pend_q;
reg iso_q, inh_q, res_q, sus_q, sus_det_q;
reg [7:0] inten_q, flag_q, epsel_q, epcsr_q;
reg iso_wait_q;
reg [31:0] rd_d;
reg err_d;
wire wr_acc = i_psel & i_penable & i_pwrite & ~o_pready;
wire rd_acc = i_psel & i_penable & ~i_pwrite & ~o_pready;
wire hit_addr = (i_paddr == `ADDR_OFS);
wire hit_power = (i_paddr == `POWER_OFS);
wire hit_inten = (i_paddr == `INTEN_OFS);
wire hit_flag = (i_paddr == `INTFLG_OFS);
wire hit_epsel = (i_paddr == `EPSEL_OFS);
wire hit_epcsr = (i_paddr == `EPCSR_OFS);
wire sus_exit = res_rise | res_q | brst_rise;
////////////////////////////////////////////////////////////////////////
usb_fdc_sreset u_sreset
(
   .I_MCLK(I_MCLK),
   .I_RST(I_RST),
   .i_req(sw_rst_req),
   .o_rst(usb_rst)
);
////////////////////////////////////////////////////////////////////////
// pins come from the bus transceiver, so they are synchronised first
always @(posedge I_MCLK or posedge I_RST)
begin
   if (I_RST)
   begin
      brst_s <= 3'h0;
      susp_s <= 3'h0;
      res_s <= 3'h0;
   end
   else
   begin
      brst_s <= {brst_s[1:0], i_bus_reset};
      susp_s <= {susp_s[1:0], i_bus_suspend};
      res_s <= {res_s[1:0], i_bus_resume};
   end
end
////////////////////////////////////////////////////////////////////////
// software reset request lives outside the reset it raises
always @(posedge I_MCLK or posedge I_RST)
begin
   if (I_RST)
      sw_rst_req <= 1'b0;
   else
      sw_rst_req <= wr_acc & hit_power & i_pwdata[`PWR_RST];
end
////////////////////////////////////////////////////////////////////////
always @(posedge I_MCLK or posedge rst_all)
begin
   if (rst_all)
   begin
      addr_q <= 7'h00;
      pend_q <= 1'b0;
      o_active_addr <= 7'h00;
      iso_q <= 1'b0;
      inh_q <= 1'b1;
      res_q <= 1'b0;
      sus_q <= 1'b0;
      sus_det_q <= 1'b0;
      inten_q <= `INTEN_RST;
      flag_q <= 8'h00;
      epsel_q <= 8'h00;
      epcsr_q <= 8'h00;
      o_fifo_flush <= 1'b0;
   end
   else
   begin
      o_fifo_flush <= brst_rise;
      if (brst_rise)
      begin
         addr_q <= 7'h00;
         pend_q <= 1'b0;
         o_active_addr <= 7'h00;
         epsel_q <= 8'h00;
         epcsr_q <= 8'h00;
         inten_q <= `INTEN_BUSRST;
         flag_q <= `INTEN_BUSRST & (8'h01 << `INT_RST);
      end
      else
      begin
         if (wr_acc & hit_addr)
         begin
            addr_q <= i_pwdata[6:0];
            pend_q <= 1'b1;
         end
         else if (pend_q & i_xfer_done)
         begin
            o_active_addr <= addr_q;
            pend_q <= 1'b0;
         end
         if (wr_acc & hit_inten)
            inten_q <= i_pwdata[7:0];
         if (wr_acc & hit_epsel)
            epsel_q <= i_pwdata[7:0];
         if (wr_acc & hit_epcsr)
            epcsr_q <= i_pwdata[7:0];
         // set wins over a write-one clear in the same cycle
         flag_q <= (flag_q & ~((wr_acc & hit_flag) ? i_pwdata[7:0] : 8'h00))
            | ({7'h00, susp_rise & sus_det_q & inten_q[`INT_SUS]}
            | {6'h00, res_rise & inten_q[`INT_RES], 1'b0});
      end
      if (wr_acc & hit_power)
      begin
         iso_q <= i_pwdata[`PWR_ISO];
         res_q <= i_pwdata[`PWR_RES];
         sus_det_q <= i_pwdata[`PWR_SUSDET];
         if (~i_pwdata[`PWR_INH])
            inh_q <= 1'b0;
      end
      if (sus_exit)
         sus_q <= 1'b0;
      else if (susp_rise & sus_det_q)
         sus_q <= 1'b1;
   end
end
////////////////////////////////////////////////////////////////////////
// iso hold is one global bit, so every iso endpoint shares this state
always @(posedge I_MCLK or posedge rst_all)
begin
   if (rst_all)
   begin
      iso_wait_q <= 1'b0;
      o_iso_send <= 1'b0;
      o_iso_zlp <= 1'b0;
   end
   else
   begin
      if (i_sof)
         iso_wait_q <= 1'b0;
      else if (i_iso_loaded & iso_q)
         iso_wait_q <= 1'b1;
      o_iso_send <= i_iso_in_token & ~iso_wait_q;
      o_iso_zlp <= i_iso_in_token & iso_wait_q;
   end
end
////////////////////////////////////////////////////////////////////////
always @*
begin
   rd_d = 32'h00000000;
   err_d = 1'b0;
   if (hit_addr)
      rd_d[7:0] = {pend_q, addr_q};
   else if (hit_power)
      rd_d[7:0] = {iso_q, 2'b00, inh_q, brst, res_q, sus_q, sus_det_q};
   else if (hit_inten)
      rd_d[7:0] = inten_q;
   else if (hit_flag)
      rd_d[7:0] = flag_q;
   else if (hit_epsel)
      rd_d[7:0] = epsel_q;
   else if (hit_epcsr)
      rd_d[7:0] = epcsr_q;
   else
      err_d = 1'b1;
end
////////////////////////////////////////////////////////////////////////
always @(posedge I_MCLK or posedge I_RST)
begin
   if (I_RST)
   begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_usb_enable <= 1'b0;
      o_suspended <= 1'b0;
      o_osc_wake <= 1'b0;
      o_resume_drive <= 1'b0;
      o_int_flags <= 8'h00;
   end
   else
   begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & err_d;
      o_prdata <= rd_acc ? rd_d : 32'h00000000;
      o_usb_enable <= ~inh_q;
      o_suspended <= sus_q;
      // any fall of suspend, software reset too, so no exit is missed
      o_osc_wake <= o_suspended & ~sus_q;
      o_resume_drive <= res_q;
      o_int_flags <= flag_q;
   end
end
endmodule
`default_nettype wire

// ### bench/usb_host_model.sv
// usb host stand-in driving bus events
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
   input wire logic I_MCLK,
   output logic [6:0] o_ev
);
   initial o_ev = 7'h00;
   // spare edge at the end keeps two drives apart
   task send(input int b, input int n);
      o_ev[b] <= 1'b1;
      repeat (n) @(posedge I_MCLK);
      o_ev[b] <= 1'b0;
      @(posedge I_MCLK);
   endtask
endmodule
`default_nettype wire

// ### bench/usb_fdc_checker.sv
// assertions on the device control ports
`timescale 1ns/1ps
`default_nettype none
module usb_fdc_checker
(
   input wire I_MCLK,
   input wire I_RST,
   input wire i_bus_reset,
   input wire i_bus_resume,
   input wire i_iso_in_token,
   input wire [6:0] o_active_addr,
   input wire o_fifo_flush,
   input wire o_suspended,
   input wire o_osc_wake,
   input wire o_iso_send,
   input wire o_iso_zlp,
   input wire [7:0] o_int_flags
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   // bus events pass a two-flop synchroniser first
   sequence s_flush; ##[1:6] o_fifo_flush; endsequence
   property p_flush; $rose(i_bus_reset) |-> s_flush; endproperty
   a_flush: assert property (p_flush) else $error("no flush");
   property p_clr; $rose(o_fifo_flush) |-> ##[0:1] o_active_addr == 7'h00;
   endproperty
   a_clr: assert property (p_clr) else $error("addr kept");
   property p_rflag; $rose(o_fifo_flush) |-> ##[0:2] o_int_flags == 8'h04;
   endproperty
   a_rflag: assert property (p_rflag) else $error("flags");
   property p_wake; $fell(o_suspended) |-> ##[0:1] o_osc_wake; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_exit;
      $rose(i_bus_resume) && o_suspended |-> ##[1:6] !o_suspended;
   endproperty
   a_exit: assert property (p_exit) else $error("stuck");
   property p_zlp; o_iso_zlp |-> $past(i_iso_in_token); endproperty
   a_zlp: assert property (p_zlp) else $error("zlp");
   property p_send; o_iso_send |-> $past(i_iso_in_token); endproperty
   a_send: assert property (p_send) else $error("send");
   property p_one; !(o_iso_send && o_iso_zlp); endproperty
   a_one: assert property (p_one) else $error("both");
endmodule
bind usb_fdc usb_fdc_checker i_chk (.*);
`default_nettype wire

// ### bench/usb_fdc_bench.sv
// self-checking bench for usb function device control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, e, g)
module usb_fdc_bench;
   logic I_MCLK, I_RST, i_psel, i_penable, i_pwrite, err;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, v;
   wire [31:0] o_prdata;
   wire o_pready, o_pslverr, o_fifo_flush, o_usb_enable, o_suspended;
   wire o_osc_wake, o_resume_drive, o_iso_send, o_iso_zlp, i_sof;
   wire [6:0] o_active_addr, ev;
   wire [7:0] o_int_flags;
   wire i_bus_reset, i_bus_suspend, i_bus_resume, i_xfer_done;
   wire i_iso_loaded, i_iso_in_token;
   int n_errors, n_checks, cyc, n_wake, n_zlp, n_send;
   assign {i_iso_in_token, i_iso_loaded, i_sof, i_xfer_done,
      i_bus_resume, i_bus_suspend, i_bus_reset} = ev;
   usb_fdc i_dut (.*);
   usb_host_model i_host (.I_MCLK, .o_ev(ev));
   initial
   begin
      I_MCLK = 1'b0;
      forever #4 I_MCLK = ~I_MCLK;
   end
   always @(posedge I_MCLK)
   begin
      cyc <= cyc + 1;
      n_wake <= n_wake + int'(o_osc_wake);
      n_zlp <= n_zlp + int'(o_iso_zlp);
      n_send <= n_send + int'(o_iso_send);
      if (cyc == 3000)
         results(1);
   end
   task results(input int t);
      n_errors = n_errors + t;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge I_MCLK);
   endtask
   task apb(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge I_MCLK);
      {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, we, a, d};
      @(posedge I_MCLK);
      i_penable <= 1'b1;
      // only the bench timeout ends a wait for pready
      do @(posedge I_MCLK); while (o_pready !== 1'b1);
      v = o_prdata;
      err = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      `CHK(n, e, v);
   endtask
   task t_reg;
      rd(12'h000, 32'h00, "addr");
      rd(12'h004, 32'h10, "pwr");
      rd(12'h020, 32'h00, "unmapped");
      `CHK("slverr", 1'b1, err);
      wr(12'h004, 32'h00);
      wr(12'h004, 32'h10);
      rd(12'h004, 32'h00, "inh");
      `CHK("en", 1'b1, o_usb_enable);
      wr(12'h004, 32'h08);
      tick(8);
      rd(12'h004, 32'h10, "swrst");
      `CHK("dis", 1'b0, o_usb_enable);
      wr(12'h004, 32'h00);
      wr(12'h000, 32'h25);
      rd(12'h000, 32'hA5, "pend");
      `CHK("old", 7'h00, o_active_addr);
      i_host.send(3, 1);
      rd(12'h000, 32'h25, "done");
      `CHK("new", 7'h25, o_active_addr);
      $display("t_reg done");
   endtask
   task t_bus;
      wr(12'h010, 32'h03);
      wr(12'h008, 32'h00);
      fork
         i_host.send(0, 12);
         begin
            // status bit lags the pin by the synchroniser
            tick(4);
            rd(12'h004, 32'h08, "busrst");
         end
      join
      rd(12'h010, 32'h00, "sel");
      rd(12'h000, 32'h00, "addr0");
      rd(12'h008, 32'hFE, "inten");
      rd(12'h00C, 32'h04, "flag");
      $display("t_bus done");
   endtask
   task t_sus;
      wr(12'h008, 32'h03);
      wr(12'h00C, 32'hFF);
      wr(12'h004, 32'h01);
      i_host.send(1, 3);
      rd(12'h00C, 32'h01, "susflag");
      `CHK("sus", 1'b1, o_suspended);
      i_host.send(2, 3);
      rd(12'h00C, 32'h03, "resflag");
      `CHK("exit", 1'b0, o_suspended);
      `CHK("wake", 1, n_wake);
      i_host.send(1, 3);
      tick(1);
      `CHK("sus2", 1'b1, o_suspended);
      wr(12'h004, 32'h05);
      tick(3);
      `CHK("drive", 1'b1, o_resume_drive);
      `CHK("wake2", 2, n_wake);
      `CHK("gen", 1'b0, o_suspended);
      wr(12'h004, 32'h01);
      $display("t_sus done");
   endtask
   task t_iso;
      wr(12'h004, 32'h80);
      i_host.send(5, 1);
      i_host.send(6, 1);
      tick(1);
      `CHK("zlp", 1, n_zlp);
      i_host.send(4, 1);
      i_host.send(6, 1);
      tick(1);
      `CHK("sent", 1, n_send);
      $display("t_iso done");
   endtask
   initial
   begin
      {I_RST, i_psel, i_penable, i_pwrite} = 4'h8;
      {i_paddr, i_pwdata} = 44'h0;
      tick(12);
      I_RST <= 1'b0;
      t_reg;
      t_bus;
      t_sus;
      t_iso;
      results(0);
   end
endmodule
`default_nettype wire
